// ---- include/meb_pkg.sv ----
// Package for the external bus unit of an 8-bit single-chip controller.
// Assumes a single core clock; all counts are in core clock cycles.
package meb_pkg;

    // Machine cycle made of a fixed number of core clocks
    localparam logic [3:0] CYCLE_LAST   = 4'he;  // 15 clocks, 0..14
    localparam logic [3:0] ADDR_ON      = 4'h0;  // address or command driven
    localparam logic [3:0] ALE_ON       = 4'h1;  // latch strobe rises
    localparam logic [3:0] ALE_OFF      = 4'h4;  // latch strobe falls
    localparam logic [3:0] ADDR_OFF     = 4'h5;  // address released
    localparam logic [3:0] STB_ON       = 4'h6;  // read/write/fetch strobe on
    localparam logic [3:0] STB_OFF      = 4'hc;  // strobe off, data sampled
    localparam logic [3:0] DATA_OFF     = 4'hd;  // store data released

    // Internal program store size: fetches at or above go external
    localparam logic [11:0] INT_ROM_TOP = 12'h400;

    // Reset values
    localparam logic [7:0] PORT_RESET   = 8'hff;
    localparam logic [7:0] BUS_RESET    = 8'h00;

    // Divider for the clock brought out on test pin zero
    localparam logic [2:0] T0_DIV_LAST  = 3'h2;

    // Kind of machine cycle requested by the core
    typedef enum logic [2:0] {
        CK_IDLE   = 3'b000,
        CK_FETCH  = 3'b001,
        CK_LOAD   = 3'b010,
        CK_STORE  = 3'b011,
        CK_BUSIN  = 3'b100,
        CK_BUSOUT = 3'b101,
        CK_EXPRD  = 3'b110,
        CK_EXPWR  = 3'b111
    } meb_kind_e;

    // Single-step sequencer
    typedef enum logic [1:0] {
        SS_RUN  = 2'b00,
        SS_HALT = 2'b01,
        SS_WAIT = 2'b10
    } meb_step_e;

endpackage

// ---- rtl/meb_sync.sv ----
// Two-stage synchroniser for levels arriving from the pins.
// Assumes the inputs are quasi-static compared with the core clock.
`timescale 1ns/10ps
module meb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end

endmodule

// ---- rtl/meb_quasi_port.sv ----
// Eight-bit quasi-bidirectional port with a per-bit active override.
// Assumes an external pull-up on each pin that is not driven.
`timescale 1ns/10ps
module meb_quasi_port
    import meb_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    input  wire logic [7:0] ovrEn,
    input  wire logic [7:0] ovrVal,
    input  wire logic [7:0] pinIn,
    output logic      [7:0] latchOut,
    output logic      [7:0] pinOut,
    output logic      [7:0] pinOe,
    output logic      [7:0] pinLevel
);

    // Latch leaves reset at all ones so every pin can be read at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latchOut <= PORT_RESET;
        end else if (wrEn) begin
            latchOut <= wrData;
        end
    end

    // A one in the latch only lets the pull-up through, so the pin reads outside
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_bit
            wire nxtOe  = ovrEn[b] | ~latchOut[b];
            wire nxtOut = ovrEn[b] & ovrVal[b];
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pinOe[b]  <= 1'b0;
                    pinOut[b] <= 1'b0;
                end else begin
                    pinOe[b]  <= nxtOe;
                    pinOut[b] <= nxtOut;
                end
            end
        end
    endgenerate

    // Pin levels are resynchronised before anyone reads them
    meb_sync #(.WIDTH(8)) u_pinSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  (pinIn),
        .syncOut  (pinLevel)
    );

endmodule

// ---- rtl/meb_bus_unit.sv ----
// External bus unit: multiplexed data bus, strobes, ports, test and event pins.
// Assumes a core on the same clock that offers one request per machine cycle.
`timescale 1ns/10ps
module meb_bus_unit
    import meb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Core side
    input  wire logic [2:0]  cycKind,
    input  wire logic        instrLast,
    input  wire logic [11:0] cycAddr,
    input  wire logic [7:0]  cycData,
    input  wire logic        port1Wr,
    input  wire logic        port2Wr,
    input  wire logic [7:0]  portWrData,
    input  wire logic        clockOutputEnableInstr,
    input  wire logic        eventCountStartInstr,
    output logic             cycTaken,
    output logic             cycDone,
    output logic [7:0]       rdData,
    output logic             fetchExternal,
    output logic             intRequest,
    output logic             testZeroLevel,
    output logic             testOneLevel,
    output logic             eventPulse,
    output logic             stepHalted,
    output logic [7:0]       port1Level,
    output logic [7:0]       port2Level,
    // Pin side
    input  wire logic        externalAccessInput,
    input  wire logic        singleStepInput,
    input  wire logic        intPinN,
    input  wire logic        testPinZeroIn,
    input  wire logic        testPinOneIn,
    input  wire logic [7:0]  dataBusIn,
    input  wire logic [7:0]  portOnePinsIn,
    input  wire logic [7:0]  portTwoPinsIn,
    output logic [7:0]       dataBusOut,
    output logic [7:0]       dataBusOe,
    output logic             testPinZeroOut,
    output logic             testPinZeroOe,
    output logic             addrLatchStrobe,
    output logic             progStoreStrobeN,
    output logic             readStrobeN,
    output logic             writeStrobeN,
    output logic             expanderStrobeN,
    output logic [7:0]       portOnePinsOut,
    output logic [7:0]       portOnePinsOe,
    output logic [7:0]       portTwoPinsOut,
    output logic [7:0]       portTwoPinsOe
);

    // ---------------------------------------------------------------
    // Pin synchronisers; nothing reads a pin before two flip-flops
    // ---------------------------------------------------------------
    logic [7:0] busSync;
    logic [4:0] ctlSync;

    meb_sync #(.WIDTH(8)) u_busSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  (dataBusIn),
        .syncOut  (busSync)
    );

    meb_sync #(.WIDTH(5)) u_ctlSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  ({externalAccessInput, singleStepInput, ~intPinN,
                    testPinZeroIn, testPinOneIn}),
        .syncOut  (ctlSync)
    );

    wire eaLevel   = ctlSync[4];
    wire stepLevel = ctlSync[3];
    wire intLevel  = ctlSync[2];
    wire t0Level   = ctlSync[1];
    wire t1Level   = ctlSync[0];

    // ---------------------------------------------------------------
    // Machine cycle timing and single-step sequencer
    // ---------------------------------------------------------------
    logic [3:0] phase_ff;
    meb_step_e  step_ff;
    meb_kind_e  kind_ff;
    logic       last_ff;
    logic [11:0] addr_ff;
    logic [7:0] wdat_ff;
    logic       ext_ff;

    // Cycle counter freezes in phase zero only while halted
    wire       cycEnd   = (phase_ff == CYCLE_LAST);
    wire       halted   = (step_ff != SS_RUN);
    wire       cycBegin = (phase_ff == ADDR_ON) && !halted;
    wire [3:0] nxt_phase = halted ? ADDR_ON :
                           (cycEnd ? ADDR_ON : phase_ff + 4'h1);

    // Halt after the last cycle of an instruction; advance on release
    meb_step_e nxt_step;
    always_comb begin
        nxt_step = step_ff;
        case (step_ff)
            SS_RUN:  if (cycEnd && last_ff && stepLevel) nxt_step = SS_HALT;
            SS_HALT: if (!stepLevel) nxt_step = SS_WAIT;
            SS_WAIT: nxt_step = SS_RUN;
            default: nxt_step = SS_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= ADDR_ON;
            step_ff  <= SS_RUN;
        end else begin
            phase_ff <= nxt_phase;
            step_ff  <= nxt_step;
        end
    end

    // Request is sampled at the start of every running cycle
    wire isFetch = (meb_kind_e'(cycKind) == CK_FETCH);
    wire nxt_ext = eaLevel || (cycAddr >= INT_ROM_TOP);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_ff <= CK_IDLE;
            last_ff <= 1'b0;
            addr_ff <= 12'h000;
            wdat_ff <= BUS_RESET;
            ext_ff  <= 1'b0;
        end else if (cycBegin) begin
            kind_ff <= meb_kind_e'(cycKind);
            last_ff <= instrLast;
            addr_ff <= cycAddr;
            wdat_ff <= cycData;
            ext_ff  <= isFetch && nxt_ext;
        end
    end

    // ---------------------------------------------------------------
    // Decode of the current cycle
    // ---------------------------------------------------------------
    wire extFetch  = (kind_ff == CK_FETCH) && ext_ff;
    wire isRead    = (kind_ff == CK_LOAD) || (kind_ff == CK_BUSIN);
    wire isWrite   = (kind_ff == CK_STORE) || (kind_ff == CK_BUSOUT);
    wire isExp     = (kind_ff == CK_EXPRD) || (kind_ff == CK_EXPWR);
    wire hasAddr   = extFetch || (kind_ff == CK_LOAD) || (kind_ff == CK_STORE);
    wire inAddr    = (phase_ff < ADDR_OFF) && !halted;
    wire inStrobe  = (phase_ff >= STB_ON) && (phase_ff < STB_OFF);
    wire inWData   = (phase_ff >= ADDR_OFF) && (phase_ff < DATA_OFF);
    wire sampleNow = (phase_ff == STB_OFF);

    // Latch pulse runs every cycle and stays high across a single-step halt
    wire nxt_ale = halted ||
                   ((phase_ff >= ALE_ON) && (phase_ff < ALE_OFF));

    // Strobes, active low as on the pins
    wire nxt_psenN = !(extFetch && inStrobe);
    wire nxt_rdN   = !(isRead && inStrobe);
    wire nxt_wrN   = !(isWrite && inStrobe);
    wire nxt_progN = !(isExp && inStrobe);

    // ---------------------------------------------------------------
    // Data bus driver and output latch
    // ---------------------------------------------------------------
    logic [7:0] busLatch_ff;
    logic       busHold_ff;

    // Bus-output value is kept in a latch and held on the bus until the next
    // non-idle cycle begins; store data only stands around its write strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busLatch_ff <= BUS_RESET;
            busHold_ff  <= 1'b0;
        end else if (cycBegin) begin
            if (meb_kind_e'(cycKind) == CK_BUSOUT) begin
                busLatch_ff <= cycData;
                busHold_ff  <= 1'b1;
            end else if (meb_kind_e'(cycKind) != CK_IDLE) begin
                busHold_ff  <= 1'b0;
            end
        end
    end

    wire addrDrive  = hasAddr && inAddr;
    wire storeDrive = (kind_ff == CK_STORE) && inWData;
    wire holdDrive  = busHold_ff && !hasAddr && !isRead;
    wire nxt_busOe  = addrDrive || storeDrive || holdDrive;
    wire [7:0] nxt_busOut = addrDrive  ? addr_ff[7:0] :
                            storeDrive ? wdat_ff : busLatch_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataBusOut       <= BUS_RESET;
            dataBusOe        <= 8'h00;
            addrLatchStrobe  <= 1'b0;
            progStoreStrobeN <= 1'b1;
            readStrobeN      <= 1'b1;
            writeStrobeN     <= 1'b1;
            expanderStrobeN  <= 1'b1;
        end else begin
            dataBusOut       <= nxt_busOut;
            dataBusOe        <= {8{nxt_busOe}};
            addrLatchStrobe  <= nxt_ale;
            progStoreStrobeN <= nxt_psenN;
            readStrobeN      <= nxt_rdN;
            writeStrobeN     <= nxt_wrN;
            expanderStrobeN  <= nxt_progN;
        end
    end

    // ---------------------------------------------------------------
    // Answers to the core
    // ---------------------------------------------------------------
    logic [7:0] port2Lvl;

    // Sampled at the end of the strobe; the synchroniser delay is covered
    // by the strobe being six clocks wide
    wire [7:0] nxt_rd = (kind_ff == CK_EXPRD) ? {4'h0, port2Lvl[3:0]} :
                                                busSync;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cycTaken      <= 1'b0;
            cycDone       <= 1'b0;
            rdData        <= BUS_RESET;
            fetchExternal <= 1'b0;
            stepHalted    <= 1'b0;
        end else begin
            cycTaken      <= cycBegin;
            cycDone       <= cycEnd;
            stepHalted    <= halted;
            if (sampleNow && (extFetch || isRead || kind_ff == CK_EXPRD)) begin
                rdData <= nxt_rd;
            end
            if (cycBegin) begin
                fetchExternal <= isFetch && nxt_ext;
            end
        end
    end

    // ---------------------------------------------------------------
    // Ports; port two low nibble is borrowed for address and expander
    // ---------------------------------------------------------------
    wire [3:0] expNib = (inAddr || kind_ff == CK_EXPWR) ?
                        (inAddr ? addr_ff[3:0] : wdat_ff[3:0]) : 4'h0;
    wire expDrive = isExp && (inAddr || (kind_ff == CK_EXPWR && inWData));
    wire pcDrive  = extFetch && inAddr;
    wire [7:0] p2OvrEn  = {4'h0, {4{pcDrive || expDrive}}};
    wire [7:0] p2OvrVal = {4'h0, pcDrive ? addr_ff[11:8] : expNib};

    meb_quasi_port u_port1 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (port1Wr),
        .wrData   (portWrData),
        .ovrEn    (8'h00),
        .ovrVal   (8'h00),
        .pinIn    (portOnePinsIn),
        .latchOut (),
        .pinOut   (portOnePinsOut),
        .pinOe    (portOnePinsOe),
        .pinLevel (port1Level)
    );

    meb_quasi_port u_port2 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (port2Wr),
        .wrData   (portWrData),
        .ovrEn    (p2OvrEn),
        .ovrVal   (p2OvrVal),
        .pinIn    (portTwoPinsIn),
        .latchOut (),
        .pinOut   (portTwoPinsOut),
        .pinOe    (portTwoPinsOe),
        .pinLevel (port2Lvl)
    );

    assign port2Level = port2Lvl;

    // ---------------------------------------------------------------
    // Test pins and interrupt
    // ---------------------------------------------------------------
    logic       t0Mode_ff;
    logic       cntMode_ff;
    logic [2:0] t0Div_ff;
    logic       t0Clk_ff;
    logic       t1Prev_ff;

    // Clock output stays on until reset; the core has no instruction to stop it
    wire       t0Wrap   = (t0Div_ff == T0_DIV_LAST);
    wire [2:0] nxt_div  = t0Wrap ? 3'h0 : t0Div_ff + 3'h1;
    wire       t1Rise   = t1Level && !t1Prev_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            t0Mode_ff  <= 1'b0;
            cntMode_ff <= 1'b0;
            t0Div_ff   <= 3'h0;
            t0Clk_ff   <= 1'b0;
            t1Prev_ff  <= 1'b0;
        end else begin
            if (clockOutputEnableInstr) t0Mode_ff <= 1'b1;
            if (eventCountStartInstr) cntMode_ff <= 1'b1;
            t0Div_ff  <= nxt_div;
            if (t0Wrap) t0Clk_ff <= ~t0Clk_ff;
            t1Prev_ff <= t1Level;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            testPinZeroOut <= 1'b0;
            testPinZeroOe  <= 1'b0;
            testZeroLevel  <= 1'b0;
            testOneLevel   <= 1'b0;
            eventPulse     <= 1'b0;
            intRequest     <= 1'b0;
        end else begin
            testPinZeroOut <= t0Mode_ff & t0Clk_ff;
            testPinZeroOe  <= t0Mode_ff;
            testZeroLevel  <= t0Level;
            testOneLevel   <= t1Level;
            eventPulse     <= cntMode_ff && t1Rise;
            intRequest     <= intLevel;
        end
    end

endmodule

// ---- tb/meb_bus_unit_props.sv ----
// Concurrent checks on the pins of the external bus unit.
// Assumes the single core clock and the active-low asynchronous reset.
`timescale 1ns/10ps
module meb_bus_unit_props (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       port1Wr,
    input wire logic [7:0] portWrData,
    input wire logic       intPinN,
    input wire logic       intRequest,
    input wire logic [7:0] dataBusOut,
    input wire logic [7:0] dataBusOe,
    input wire logic       addrLatchStrobe,
    input wire logic       progStoreStrobeN,
    input wire logic       readStrobeN,
    input wire logic       writeStrobeN,
    input wire logic       expanderStrobeN,
    input wire logic       stepHalted,
    input wire logic [7:0] portOnePinsOe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Short names for the strobes keep the properties readable
    wire ale = addrLatchStrobe;
    wire psN = progStoreStrobeN;
    wire rdN = readStrobeN;
    wire wrN = writeStrobeN;
    wire exN = expanderStrobeN;
    // Strobe shapes and bus ownership, each tied to its cause
    // A single-step halt holds the latch strobe high on purpose, so its rise is not a pulse
    property p_ale; $rose(ale) && !stepHalted |-> ale[*3] ##1 (!ale)[*8]; endproperty
    a_ale: assert property (p_ale) else $error("latch strobe shape wrong");
    property p_fa; $fell(psN) |-> $past(ale, 3) && $past(dataBusOe[0], 3); endproperty
    a_fa: assert property (p_fa) else $error("fetch without address phase");
    property p_ps; $fell(psN) |-> (!psN)[*6] ##1 psN; endproperty
    a_ps: assert property (p_ps) else $error("program strobe width wrong");
    property p_rz; !rdN || !psN |-> dataBusOe == 8'h00; endproperty
    a_rz: assert property (p_rz) else $error("bus driven during read");
    property p_wd; !wrN |-> dataBusOe == 8'hff; endproperty
    a_wd: assert property (p_wd) else $error("bus not driven during write");
    property p_ws; !wrN && $past(!wrN) |-> $stable(dataBusOut); endproperty
    a_ws: assert property (p_ws) else $error("write data moved");
    property p_ex; $fell(exN) |-> (!exN)[*6] ##1 exN; endproperty
    a_ex: assert property (p_ex) else $error("expander strobe width wrong");
    property p_pw; port1Wr |=> ##1 portOnePinsOe == ~$past(portWrData, 2); endproperty
    a_pw: assert property (p_pw) else $error("port drive wrong");
    property p_ir; (!intPinN)[*4] |-> intRequest; endproperty
    a_ir: assert property (p_ir) else $error("interrupt not seen");
endmodule

bind meb_bus_unit meb_bus_unit_props props_u (.*);

// ---- tb/meb_ext_mem.sv ----
// Model of external program and data memory on the multiplexed bus.
// Assumes active-low strobes and one bus enable shared by all bits.
`timescale 1ns/10ps
module meb_ext_mem (
    input  wire logic        core_clk,
    input  wire logic        slow,
    input  wire logic        ale,
    input  wire logic        psN,
    input  wire logic        rdN,
    input  wire logic        wrN,
    input  wire logic [7:0]  busOut,
    input  wire logic [7:0]  busOe,
    input  wire logic [3:0]  p2Nib,
    output logic      [7:0]  busIn,
    output logic      [11:0] addrSeen,
    output logic      [7:0]  wrSeen
);
    logic [7:0] lastVal = 8'h00;
    logic [2:0] stbCnt  = 3'h0;
    logic       aleQ    = 1'b0;
    // Slow mode holds valid data back for two clocks of the strobe
    wire stbOn = !psN || !rdN;
    wire ready = stbOn && (!slow || stbCnt > 3'h1);
    // A released bus shows the inverse of its last value, never a stale copy
    assign busIn = busOe[0] ? busOut : ready ? {addrSeen[3:0], addrSeen[7:4]} ^ 8'h5a : ~lastVal;
    // Address taken at the latch strobe fall, store data while write is low
    always @(posedge core_clk) begin
        aleQ <= ale;
        lastVal <= busIn;
        stbCnt <= stbOn ? stbCnt + 3'h1 : 3'h0;
        if (aleQ && !ale) addrSeen <= {p2Nib, busIn};
        if (!wrN) wrSeen <= busIn;
    end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the external bus unit, random and corner cycles.
// Assumes the memory model meb_ext_mem on the bus and outside port levels.
`timescale 1ns/10ps
module tb_top;
    import meb_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, instrLast = 1'b0, slow = 1'b0;
    logic        port1Wr = 1'b0, port2Wr = 1'b0, intPinN = 1'b1;
    logic        clockOutputEnableInstr = 1'b0, eventCountStartInstr = 1'b0;
    logic        externalAccessInput = 1'b0, singleStepInput = 1'b0;
    logic        testPinZeroIn = 1'b0, testPinOneIn = 1'b0;
    logic [2:0]  cycKind = 3'h0;
    logic [11:0] cycAddr = 12'h000, addrSeen;
    logic [7:0]  cycData = 8'h00, portWrData = 8'h00, ext1 = 8'h00, ext2 = 8'hff;
    logic [7:0]  lf = 8'h5d, wrSeen, dataBusIn;
    // Everything the unit drives, seen by the checks and the memory model
    wire         cycTaken, cycDone, fetchExternal, intRequest, testZeroLevel, testOneLevel;
    wire         eventPulse, stepHalted, testPinZeroOut, testPinZeroOe, addrLatchStrobe;
    wire         progStoreStrobeN, readStrobeN, writeStrobeN, expanderStrobeN;
    wire [7:0]   rdData, port1Level, port2Level, dataBusOut, dataBusOe;
    wire [7:0]   portOnePinsOut, portOnePinsOe, portTwoPinsOut, portTwoPinsOe;
    int          bad_count = 0, tests_run = 0, nPs = 0, nRd = 0, nWr = 0, nEx = 0;
    int          nEv = 0, nT0 = 0, base = 0;
    // Pins not driven by the unit settle at the outside level
    wire [7:0] portOnePinsIn = (portOnePinsOe & portOnePinsOut) | (~portOnePinsOe & ext1);
    wire [7:0] portTwoPinsIn = (portTwoPinsOe & portTwoPinsOut) | (~portTwoPinsOe & ext2);
    meb_bus_unit dut_u (.*);
    meb_ext_mem mem_u (.core_clk, .slow, .ale(addrLatchStrobe), .psN(progStoreStrobeN),
        .rdN(readStrobeN), .wrN(writeStrobeN), .busOut(dataBusOut), .busOe(dataBusOe),
        .p2Nib(portTwoPinsIn[3:0]), .busIn(dataBusIn), .addrSeen, .wrSeen);
    // Strobe and clock counters are judged by their change; the event count by its total
    always @(negedge progStoreStrobeN) nPs++;
    always @(negedge readStrobeN) nRd++;
    always @(negedge writeStrobeN) nWr++;
    always @(negedge expanderStrobeN) nEx++;
    always @(posedge testPinZeroOut) nT0++;
    always @(posedge core_clk) if (eventPulse === 1'b1) nEv++;
    initial forever #5 core_clk = ~core_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Expected strobes as {program, read, write, expander}
    function automatic logic [3:0] stbOf(input logic [2:0] k, input logic [11:0] a);
        case (k)
            CK_FETCH: return (externalAccessInput || a >= INT_ROM_TOP) ? 4'h8 : 4'h0;
            CK_LOAD, CK_BUSIN: return 4'h4;
            CK_STORE, CK_BUSOUT: return 4'h2;
            default: return 4'h1;
        endcase
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic pw(input logic two, input logic [7:0] v);
        port1Wr <= !two;
        port2Wr <= two;
        portWrData <= v;
        wt(1);
        port1Wr <= 1'b0;
        port2Wr <= 1'b0;
        wt(5);
    endtask
    // Six flips of test pin one give three rising edges
    task automatic tg();
        for (int i = 0; i < 6; i++) begin
            wt(4);
            testPinOneIn <= ~testPinOneIn;
        end
        wt(8);
    endtask
    // One machine cycle: hold the request until taken, then judge the outcome
    task automatic cyc(input logic [2:0] k, input logic [11:0] a, input logic [7:0] d);
        int p, r, w, x, i;
        logic [3:0] s;
        p = nPs;
        r = nRd;
        w = nWr;
        x = nEx;
        cycKind <= k;
        cycAddr <= a;
        cycData <= d;
        wt(1);
        for (i = 0; i < 40 && cycTaken !== 1'b1; i++) wt(1);
        cycKind <= CK_IDLE;
        s = stbOf(k, a);
        chk({11'h000, fetchExternal}, {11'h000, s[3]});
        for (i = 0; i < 20 && cycDone !== 1'b1; i++) wt(1);
        chk({11'h000, cycDone}, 12'h001);
        s = {nPs != p, nRd != r, nWr != w, nEx != x};
        chk({8'h00, s}, {8'h00, stbOf(k, a)});
        case (k)
            CK_FETCH: if (s[3]) begin
                chk(addrSeen, a);
                chk({4'h0, rdData}, {4'h0, {a[3:0], a[7:4]} ^ 8'h5a});
            end
            CK_LOAD: begin
                chk({4'h0, addrSeen[7:0]}, {4'h0, a[7:0]});
                chk({4'h0, rdData}, {4'h0, {a[3:0], a[7:4]} ^ 8'h5a});
            end
            CK_STORE: chk({4'h0, wrSeen}, {4'h0, d});
            CK_BUSOUT: begin
                wt(3);
                chk({dataBusOe[3:0], dataBusOut}, {4'hf, d});
            end
            CK_EXPRD: chk({8'h00, rdData[3:0]}, {8'h00, ext2[3:0]});
            default: ;
        endcase
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Cuts a hang short well past the expected run of under a thousand clocks
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
    initial begin
        wt(16);
        rst_n <= 1'b1;
        ext1 <= 8'h3a;
        wt(5);
        chk({4'h0, port1Level}, 12'h03a);
        chk({4'h0, port2Level}, 12'h0ff);
        pw(1'b0, 8'h0f);
        chk({4'h0, port1Level}, 12'h00a);
        pw(1'b1, 8'hff);
        intPinN <= 1'b0;
        testPinZeroIn <= 1'b1;
        tg();
        chk({nEv[8:0], intRequest, testZeroLevel, testPinZeroOe}, 12'h006);
        // A rise before counting is enabled must show as a level but never count
        testPinOneIn <= 1'b1;
        wt(4);
        chk({11'h000, testOneLevel}, 12'h001);
        intPinN <= 1'b1;
        clockOutputEnableInstr <= 1'b1;
        eventCountStartInstr <= 1'b1;
        wt(1);
        clockOutputEnableInstr <= 1'b0;
        eventCountStartInstr <= 1'b0;
        tg();
        base = nT0;
        wt(60);
        chk(12'(nT0 - base), 12'h00a);
        chk(12'(nEv), 12'h003);
        cyc(CK_FETCH, 12'h3ff, 8'h00);
        cyc(CK_FETCH, 12'h400, 8'h00);
        externalAccessInput <= 1'b1;
        wt(4);
        cyc(CK_FETCH, 12'h000, 8'h00);
        for (int n = 0; n < 30; n++) begin
            lf = lfsr(lf);
            slow <= lf[7];
            ext2 <= (lf[2:0] == CK_EXPRD || n == 5) ? lfsr(lf) : 8'hff;
            cyc((n < 7) ? 3'(n + 1) : (lf[2:0] == 3'h0) ? CK_BUSOUT : lf[2:0],
                {lf[3:0], lfsr(lf)}, ~lf);
        end
        singleStepInput <= 1'b1;
        instrLast <= 1'b1;
        cyc(CK_STORE, 12'h0c3, 8'h5a);
        instrLast <= 1'b0;
        base = 0;
        repeat (20) begin
            wt(1);
            if (cycTaken === 1'b1) base++;
        end
        chk({base[9:0], stepHalted, addrLatchStrobe}, 12'h003);
        singleStepInput <= 1'b0;
        cyc(CK_LOAD, 12'h0c3, 8'h00);
        stop_test();
    end
endmodule
